/* core/eisfp_pkg.sv */
// Constants for the external interrupt select, filter and priority block.
package eisfp_pkg;
    localparam logic [7:0] ADDR_DMA_CFG   = 8'h94;
    localparam logic [7:0] ADDR_PRIO2_LOW = 8'hA6;
    localparam logic [7:0] ADDR_PRIO2_HI  = 8'hA7;
    localparam logic [7:0] ADDR_XI_CFG    = 8'hC1;
    localparam logic [3:0] PAGE_DMA       = 4'h8;
    localparam logic [3:0] PAGE_XI0       = 4'h0;
    localparam logic [3:0] PAGE_XI1       = 4'h1;
    localparam logic [3:0] PAGE_XI2       = 4'h2;
    localparam logic [7:0] RST_REG        = 8'h00;
    // Bit 5 of the priority registers is not stored and reads as zero.
    localparam logic [7:0] PRIO2_MASK     = 8'hDF;
    localparam logic [7:0] DMA_CFG_MASK   = 8'hC0;
    localparam int         DMA_PRIO_HI    = 7;
    localparam int         DMA_PRIO_LO    = 6;
    localparam int         DIV6_COUNT     = 6;
    localparam int         FILT_SAMPLES   = 3;
    localparam logic       IRQ_IDLE_LEVEL = 1'b1;
    localparam logic [1:0] FILT_OFF       = 2'b00;
    localparam logic [1:0] FILT_SYSTEM_CLOCK    = 2'b01;
    localparam logic [1:0] FILT_DIV6      = 2'b10;
    localparam logic [1:0] FILT_BAUD      = 2'b11;
endpackage : eisfp_pkg

/* core/eisfp_filter.sv */
// Three-sample glitch filter for one external interrupt input.
`timescale 1ns/1ps
`default_nettype none
module eisfp_filter (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rstn,
    // Control
    input  wire logic i_bypass,
    input  wire logic i_tick,
    // Data
    input  wire logic i_raw,
    output logic      o_level
);
    logic [eisfp_pkg::FILT_SAMPLES-2:0] hist_ff;
    logic [eisfp_pkg::FILT_SAMPLES-2:0] nxt_hist;
    logic                               level_ff;
    logic                               nxt_level;

    always_comb begin
        nxt_hist  = hist_ff;
        nxt_level = level_ff;
        if (i_bypass) begin
            nxt_level = i_raw;
            nxt_hist  = {(eisfp_pkg::FILT_SAMPLES-1){i_raw}};
        end else if (i_tick) begin
            nxt_hist = {hist_ff[eisfp_pkg::FILT_SAMPLES-3:0], i_raw};
            // The current tick and the two before must all agree.
            if (hist_ff == {(eisfp_pkg::FILT_SAMPLES-1){i_raw}}) begin
                nxt_level = i_raw;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hist_ff  <= {(eisfp_pkg::FILT_SAMPLES-1){eisfp_pkg::IRQ_IDLE_LEVEL}};
            level_ff <= eisfp_pkg::IRQ_IDLE_LEVEL;
        end else begin
            hist_ff  <= nxt_hist;
            level_ff <= nxt_level;
        end
    end

    assign o_level = level_ff;
endmodule : eisfp_filter
`default_nettype wire

/* core/eisfp_top.sv */
// External interrupt pin select, filter, flags and second-group priority.
`timescale 1ns/1ps
`default_nettype none
module eisfp_top #(
    parameter int N_IRQ = 4
) (
    // Clock and reset
    input  wire logic               i_sys_clk,
    input  wire logic               i_rstn,
    // Special-function register port
    input  wire logic [7:0]         i_sfr_addr,
    input  wire logic [3:0]         i_sfr_page,
    input  wire logic               i_sfr_wr,
    input  wire logic               i_sfr_rd,
    input  wire logic [7:0]         i_sfr_wdata,
    output logic      [7:0]         o_sfr_rdata,
    output logic                    o_sfr_hit,
    // Candidate port pins, eight per interrupt, active low, and the serial 0 baud overflow tick
    input  wire logic [7:0]         i_ext_irq_in_0,
    input  wire logic [7:0]         i_ext_irq_in_1,
    input  wire logic [7:0]         i_ext_irq_in_2,
    input  wire logic [7:0]         i_ext_irq_in_3,
    input  wire logic               i_serial0_baud_overflow_tick,
    // Trigger and flag control
    input  wire logic [N_IRQ-1:0]   i_trig_high,
    input  wire logic [N_IRQ-1:0]   i_svc_start,
    input  wire logic [N_IRQ-1:0]   i_flag_set,
    input  wire logic [N_IRQ-1:0]   i_flag_clr,
    // Results
    output logic      [N_IRQ-1:0]   o_irq_level,
    output logic      [N_IRQ-1:0]   o_irq_flag,
    output logic      [13:0]        o_group2_level,
    output logic      [1:0]         o_dma_level
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] prio_lo_ff, prio_hi_ff, dma_cfg_ff;
    logic [7:0] xi0_ff, xi1_ff, xi2_ff;
    logic [7:0] nxt_prio_lo, nxt_prio_hi, nxt_dma_cfg;
    logic [7:0] nxt_xi0, nxt_xi1, nxt_xi2;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       hit_ff, nxt_hit;
    logic [7:0] rd_val;
    logic       rd_hit;
    logic [2:0] div_ff, nxt_div;
    logic       div6_tick;
    logic [N_IRQ-1:0] flag_ff, nxt_flag, prev_ff, nxt_prev;
    logic [N_IRQ-1:0] filt_out, raw_sel, edge_hit;
    logic [2:0]       pin_sel [N_IRQ];
    logic [1:0]       filt_code [N_IRQ];
    logic [7:0]       cand [N_IRQ];

    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [3:0] page,
                                     input logic [7:0] want_addr,
                                     input logic       any_page,
                                     input logic [3:0] want_page);
        reg_hit = (addr == want_addr) && (any_page || page == want_page);
    endfunction : reg_hit

    function automatic logic pick_pin(input logic [7:0] pins,
                                      input logic [2:0] sel);
        pick_pin = pins[sel];
    endfunction : pick_pin

    ////////////////////////////////////////////////////////////////////////
    // Register writes and read-back.
    logic w_lo, w_hi, w_dma, w_x0, w_x1, w_x2;
    assign w_lo  = reg_hit(i_sfr_addr, i_sfr_page, eisfp_pkg::ADDR_PRIO2_LOW,
                           1'b1, 4'h0);
    assign w_hi  = reg_hit(i_sfr_addr, i_sfr_page, eisfp_pkg::ADDR_PRIO2_HI,
                           1'b1, 4'h0);
    assign w_dma = reg_hit(i_sfr_addr, i_sfr_page, eisfp_pkg::ADDR_DMA_CFG,
                           1'b0, eisfp_pkg::PAGE_DMA);
    assign w_x0  = reg_hit(i_sfr_addr, i_sfr_page, eisfp_pkg::ADDR_XI_CFG,
                           1'b0, eisfp_pkg::PAGE_XI0);
    assign w_x1  = reg_hit(i_sfr_addr, i_sfr_page, eisfp_pkg::ADDR_XI_CFG,
                           1'b0, eisfp_pkg::PAGE_XI1);
    assign w_x2  = reg_hit(i_sfr_addr, i_sfr_page, eisfp_pkg::ADDR_XI_CFG,
                           1'b0, eisfp_pkg::PAGE_XI2);

    always_comb begin
        nxt_prio_lo = prio_lo_ff;
        nxt_prio_hi = prio_hi_ff;
        nxt_dma_cfg = dma_cfg_ff;
        nxt_xi0     = xi0_ff;
        nxt_xi1     = xi1_ff;
        nxt_xi2     = xi2_ff;
        if (i_sfr_wr) begin
            // Bit 5 is dropped, so a stray one there has no effect.
            if (w_lo) nxt_prio_lo = i_sfr_wdata & eisfp_pkg::PRIO2_MASK;
            if (w_hi) nxt_prio_hi = i_sfr_wdata & eisfp_pkg::PRIO2_MASK;
            if (w_dma) nxt_dma_cfg = i_sfr_wdata & eisfp_pkg::DMA_CFG_MASK;
            if (w_x0) nxt_xi0 = i_sfr_wdata;
            if (w_x1) nxt_xi1 = i_sfr_wdata;
            if (w_x2) nxt_xi2 = i_sfr_wdata;
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 8'h00;
        if (w_lo) begin
            rd_val = prio_lo_ff;
        end else if (w_hi) begin
            rd_val = prio_hi_ff;
        end else if (w_dma) begin
            rd_val = dma_cfg_ff;
        end else if (w_x0) begin
            rd_val = xi0_ff;
        end else if (w_x1) begin
            rd_val = xi1_ff;
        end else if (w_x2) begin
            rd_val = xi2_ff;
        end else begin
            rd_hit = 1'b0;
        end
        nxt_rdata = i_sfr_rd ? rd_val : rdata_ff;
        nxt_hit   = i_sfr_rd ? rd_hit : 1'b0;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prio_lo_ff <= eisfp_pkg::RST_REG;
            prio_hi_ff <= eisfp_pkg::RST_REG;
            dma_cfg_ff <= eisfp_pkg::RST_REG;
            xi0_ff     <= eisfp_pkg::RST_REG;
            xi1_ff     <= eisfp_pkg::RST_REG;
            xi2_ff     <= eisfp_pkg::RST_REG;
            rdata_ff   <= eisfp_pkg::RST_REG;
            hit_ff     <= 1'b0;
        end else begin
            prio_lo_ff <= nxt_prio_lo;
            prio_hi_ff <= nxt_prio_hi;
            dma_cfg_ff <= nxt_dma_cfg;
            xi0_ff     <= nxt_xi0;
            xi1_ff     <= nxt_xi1;
            xi2_ff     <= nxt_xi2;
            rdata_ff   <= nxt_rdata;
            hit_ff     <= nxt_hit;
        end
    end

    assign o_sfr_rdata = rdata_ff;
    assign o_sfr_hit   = hit_ff;

    ////////////////////////////////////////////////////////////////////////
    // Priority levels, high bit above low bit.
    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_lvl
            localparam int B = (g < 5) ? g : g + 1;
            assign o_group2_level[2*g+1:2*g] =
                {prio_hi_ff[B], prio_lo_ff[B]};
        end
    endgenerate
    assign o_dma_level = {dma_cfg_ff[eisfp_pkg::DMA_PRIO_HI],
                          dma_cfg_ff[eisfp_pkg::DMA_PRIO_LO]};

    ////////////////////////////////////////////////////////////////////////
    // Field assembly from the three paged registers.
    always_comb begin
        pin_sel[0] = {xi1_ff[6], xi0_ff[5:4]};
        pin_sel[1] = {xi1_ff[7], xi0_ff[7:6]};
        pin_sel[2] = {xi2_ff[0], xi1_ff[5:4]};
        pin_sel[3] = xi2_ff[3:1];
        cand[0]    = i_ext_irq_in_0;
        cand[1]    = i_ext_irq_in_1;
        cand[2]    = i_ext_irq_in_2;
        cand[3]    = i_ext_irq_in_3;
    end

    // Divide-by-six enable for the slow filter rate.
    always_comb begin
        div6_tick = (div_ff == 3'(eisfp_pkg::DIV6_COUNT - 1));
        nxt_div   = div6_tick ? 3'h0 : div_ff + 3'h1;
    end

    generate
        for (g = 0; g < N_IRQ; g++) begin : g_irq
            logic tick;
            assign filt_code[g] = {xi1_ff[g], xi0_ff[g]};
            assign raw_sel[g]   = pick_pin(cand[g], pin_sel[g]);
            always_comb begin
                case (filt_code[g])
                    eisfp_pkg::FILT_SYSTEM_CLOCK: tick = 1'b1;
                    eisfp_pkg::FILT_DIV6:   tick = div6_tick;
                    eisfp_pkg::FILT_BAUD:   tick = i_serial0_baud_overflow_tick;
                    default:                tick = 1'b0;
                endcase
            end
            eisfp_filter u_filt (
                .i_sys_clk (i_sys_clk),
                .i_rstn    (i_rstn),
                .i_bypass  (filt_code[g] == eisfp_pkg::FILT_OFF),
                .i_tick    (tick),
                .i_raw     (raw_sel[g]),
                .o_level   (filt_out[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Edge flags: a detected edge or CPU set wins over any clear.
    always_comb begin
        nxt_prev = filt_out;
        edge_hit = (i_trig_high & filt_out & ~prev_ff)
                 | (~i_trig_high & ~filt_out & prev_ff);
        nxt_flag = (flag_ff & ~i_svc_start & ~i_flag_clr)
                 | edge_hit | i_flag_set;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_ff  <= 3'h0;
            prev_ff <= {N_IRQ{eisfp_pkg::IRQ_IDLE_LEVEL}};
            flag_ff <= '0;
        end else begin
            div_ff  <= nxt_div;
            prev_ff <= nxt_prev;
            flag_ff <= nxt_flag;
        end
    end

    assign o_irq_level = filt_out;
    assign o_irq_flag  = flag_ff;
endmodule : eisfp_top
`default_nettype wire

/* verification/eisfp_asserts.sv */
// Port-level checks for the select, filter and priority block.
`timescale 1ns/1ps
`default_nettype none
module eisfp_asserts #(
    parameter int N_IRQ = 4
) (
    // Clock, reset and register port
    input wire logic             i_sys_clk,
    input wire logic             i_rstn,
    input wire logic [7:0]       i_sfr_addr,
    input wire logic [3:0]       i_sfr_page,
    input wire logic             i_sfr_wr,
    input wire logic             i_sfr_rd,
    input wire logic [7:0]       i_sfr_wdata,
    input wire logic [7:0]       o_sfr_rdata,
    input wire logic             o_sfr_hit,
    // Flags and levels
    input wire logic [N_IRQ-1:0] i_svc_start,
    input wire logic [N_IRQ-1:0] i_flag_set,
    input wire logic [N_IRQ-1:0] i_flag_clr,
    input wire logic [N_IRQ-1:0] o_irq_level,
    input wire logic [N_IRQ-1:0] o_irq_flag,
    input wire logic [13:0]      o_group2_level,
    input wire logic [1:0]       o_dma_level
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    chk_prio_read_hit: assert property (i_sfr_rd && i_sfr_addr[7:1] == 7'h53
        |=> o_sfr_hit && !o_sfr_rdata[5]) else $error("priority read wrong");
    chk_cfg_page_miss: assert property (i_sfr_rd && i_sfr_addr == 8'hC1
        && i_sfr_page > 4'h2 |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
        else $error("config read off page");
    chk_dma_page_only: assert property (i_sfr_rd && i_sfr_addr == 8'h94
        |=> o_sfr_hit == ($past(i_sfr_page) == 4'h8)) else $error("dma page");
    chk_dma_level_set: assert property (i_sfr_wr && i_sfr_addr == 8'h94
        && i_sfr_page == 4'h8 |=> o_dma_level == $past(i_sfr_wdata[7:6]))
        else $error("dma level wrong");
    chk_low_prio_lvl: assert property (i_sfr_wr && i_sfr_addr == 8'hA6
        ##1 !i_sfr_wr |=> o_group2_level[12] == $past(i_sfr_wdata[7], 2))
        else $error("low priority level wrong");
    chk_high_prio_lvl: assert property (i_sfr_wr && i_sfr_addr == 8'hA7
        ##1 !i_sfr_wr |=> o_group2_level[1] == $past(i_sfr_wdata[0], 2))
        else $error("high priority level wrong");
    chk_flag_set_now: assert property (i_flag_set[1] |=> o_irq_flag[1])
        else $error("flag not set");
    chk_flag_clr_now: assert property ((i_flag_clr[1] || i_svc_start[1])
        && !i_flag_set[1] && $stable(o_irq_level[1]) |=> !o_irq_flag[1])
        else $error("flag not cleared");
    chk_flag_holds: assert property (o_irq_flag[1] && !i_flag_clr[1]
        && !i_svc_start[1] |=> o_irq_flag[1]) else $error("flag lost");
endmodule : eisfp_asserts
bind eisfp_top eisfp_asserts #(.N_IRQ(N_IRQ)) u_asserts (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr),
    .i_sfr_page(i_sfr_page), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit), .i_svc_start(i_svc_start),
    .i_flag_set(i_flag_set), .i_flag_clr(i_flag_clr),
    .o_irq_level(o_irq_level), .o_irq_flag(o_irq_flag),
    .o_group2_level(o_group2_level), .o_dma_level(o_dma_level));
`default_nettype wire

/* verification/eisfp_pin_src.sv */
// Port-pin source model for the four external interrupt inputs.
`timescale 1ns/1ps
`default_nettype none
module eisfp_pin_src (
    // Command from the bench
    input  wire logic [1:0] i_irq,
    input  wire logic [2:0] i_pin,
    input  wire logic       i_low,
    input  wire logic       i_tick_en,
    // Pins and baud tick toward the block
    output logic      [7:0] o_pins_0,
    output logic      [7:0] o_pins_1,
    output logic      [7:0] o_pins_2,
    output logic      [7:0] o_pins_3,
    output logic            o_tick
);
    logic [7:0] low_mask;
    // Pins not pulled low rest high, as an idle line with a pull-up does.
    assign low_mask = i_low ? (8'h01 << i_pin) : 8'h00;
    assign o_pins_0 = (i_irq == 2'h0) ? ~low_mask : 8'hFF;
    assign o_pins_1 = (i_irq == 2'h1) ? ~low_mask : 8'hFF;
    assign o_pins_2 = (i_irq == 2'h2) ? ~low_mask : 8'hFF;
    assign o_pins_3 = (i_irq == 2'h3) ? ~low_mask : 8'hFF;
    assign o_tick   = i_tick_en;
endmodule : eisfp_pin_src
`default_nettype wire

/* verification/eisfp_top_test.sv */
// Self-checking bench for the select, filter and priority block.
`timescale 1ns/1ps
`default_nettype none
module eisfp_top_test;
    logic        clk, rstn, wr, rd, tick, s_low, s_tick, hit, seen;
    logic [7:0]  addr, wdata, rdata, p0, p1, p2, p3;
    logic [3:0]  page, trig, svc, fset, fclr, lvl, flag;
    logic [1:0]  dma, s_irq;
    logic [2:0]  s_pin;
    logic [13:0] g2;
    int          num_errors = 0;
    int          tests_run = 0;
    eisfp_top #(.N_IRQ(4)) dut_u (
        .i_sys_clk(clk), .i_rstn(rstn), .i_sfr_addr(addr),
        .i_sfr_page(page), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
        .i_ext_irq_in_0(p0), .i_ext_irq_in_1(p1), .i_ext_irq_in_2(p2),
        .i_ext_irq_in_3(p3), .i_serial0_baud_overflow_tick(tick),
        .i_trig_high(trig), .i_svc_start(svc), .i_flag_set(fset),
        .i_flag_clr(fclr), .o_irq_level(lvl), .o_irq_flag(flag),
        .o_group2_level(g2), .o_dma_level(dma));
    eisfp_pin_src u_src (.i_irq(s_irq), .i_pin(s_pin), .i_low(s_low),
        .i_tick_en(s_tick), .o_pins_0(p0), .o_pins_1(p1), .o_pins_2(p2),
        .o_pins_3(p3), .o_tick(tick));
    task automatic check(input string what, input logic [15:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic sfr_wr(input logic [7:0] a, input logic [3:0] p,
                          input logic [7:0] d);
        @(posedge clk);
        {addr, page, wdata, wr} <= {a, p, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] a, input logic [3:0] p,
                          input logic [7:0] d, input logic h);
        @(posedge clk);
        {addr, page, rd} <= {a, p, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("rdata", {8'h00, rdata}, {8'h00, d});
        check("hit", {15'h0000, hit}, {15'h0000, h});
    endtask : sfr_rd
    task automatic cfg(input int n, input logic [2:0] c, input logic [1:0] f);
        logic [7:0] r0, r1, r2;
        {r0, r1, r2} = 24'h00_0000;
        r0[n] = f[0];
        r1[n] = f[1];
        if (n == 0) {r1[6], r0[5:4]} = c;
        else if (n == 1) {r1[7], r0[7:6]} = c;
        else if (n == 2) {r2[0], r1[5:4]} = c;
        else r2[3:1] = c;
        sfr_wr(8'hC1, 4'h0, r0);
        sfr_wr(8'hC1, 4'h1, r1);
        sfr_wr(8'hC1, 4'h2, r2);
    endtask : cfg
    // Pulls one pin low for cyc cycles; low_seen is 0 if the level dropped.
    task automatic pulse(input int n, input logic [2:0] pin, input int cyc,
                         output logic low_seen);
        low_seen = 1'b1;
        for (int i = 0; i < cyc + 24; i++) begin
            @(posedge clk);
            {s_irq, s_pin, s_low} <= {n[1:0], pin, i < cyc};
            #1;
            low_seen = low_seen & lvl[n];
        end
    endtask : pulse
    task automatic flag_op(input logic [3:0] sv, st, cl, input logic e);
        @(posedge clk);
        {svc, fset, fclr} <= {sv, st, cl};
        @(posedge clk);
        {svc, fset, fclr} <= 12'h000;
        #1;
        check("flag", {15'h0000, flag[1]}, {15'h0000, e});
    endtask : flag_op
    ////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        for (int p = 0; p < 3; p++) sfr_rd(8'hC1, p[3:0], 8'h00, 1'b1);
        sfr_rd(8'hA6, 4'h0, 8'h00, 1'b1);
        sfr_rd(8'h94, 4'h8, 8'h00, 1'b1);
        sfr_wr(8'hA6, 4'h3, 8'hDF);
        sfr_wr(8'hA7, 4'hF, 8'hDF);
        sfr_rd(8'hA7, 4'h0, 8'hDF, 1'b1);
        check("levels", {2'b00, g2}, 16'h3FFF);
        sfr_wr(8'hA7, 4'h0, 8'h00);
        check("levels", {2'b00, g2}, 16'h1555);
        sfr_wr(8'h94, 4'h8, 8'hFF);
        sfr_wr(8'h94, 4'h0, 8'h00);
        sfr_rd(8'h94, 4'h0, 8'h00, 1'b0);
        sfr_rd(8'h94, 4'h8, 8'hC0, 1'b1);
        check("dma", {14'h0000, dma}, 16'h0003);
        for (int p = 0; p < 3; p++) sfr_wr(8'hC1, p[3:0], 8'h5A + p[7:0]);
        for (int p = 0; p < 3; p++) sfr_rd(8'hC1, p[3:0], 8'h5A + p[7:0], 1'b1);
        sfr_rd(8'hC1, 4'h3, 8'h00, 1'b0);
    endtask : test_regs
    task automatic test_pins();
        for (int n = 0; n < 4; n++) for (int c = 0; c < 8; c++) begin
            cfg(n, c[2:0], 2'b00);
            pulse(n, c[2:0], 1, seen);
            check("pin hit", {15'h0000, seen}, 16'h0000);
            pulse(n, ~c[2:0], 3, seen);
            check("pin miss", {15'h0000, seen}, 16'h0001);
        end
    endtask : test_pins
    task automatic test_filters();
        for (int n = 0; n < 4; n++) begin
            cfg(n, 3'h0, 2'b01);
            pulse(n, 3'h0, 2, seen);
            check("clk glitch", {15'h0000, seen}, 16'h0001);
            pulse(n, 3'h0, 6, seen);
            check("clk pass", {15'h0000, seen}, 16'h0000);
            cfg(n, 3'h0, 2'b10);
            pulse(n, 3'h0, 8, seen);
            check("div glitch", {15'h0000, seen}, 16'h0001);
            pulse(n, 3'h0, 20, seen);
            check("div pass", {15'h0000, seen}, 16'h0000);
            cfg(n, 3'h0, 2'b11);
            pulse(n, 3'h0, 20, seen);
            check("no tick", {15'h0000, seen}, 16'h0001);
            @(posedge clk);
            s_tick <= 1'b1;
            pulse(n, 3'h0, 5, seen);
            check("tick pass", {15'h0000, seen}, 16'h0000);
            @(posedge clk);
            s_tick <= 1'b0;
        end
    endtask : test_filters
    task automatic test_flags();
        cfg(1, 3'h0, 2'b00);
        flag_op(4'h0, 4'h0, 4'h2, 1'b0);
        pulse(1, 3'h0, 2, seen);
        check("edge flag", {15'h0000, flag[1]}, 16'h0001);
        flag_op(4'h2, 4'h0, 4'h0, 1'b0);
        flag_op(4'h0, 4'h2, 4'h0, 1'b1);
        flag_op(4'h0, 4'h0, 4'h2, 1'b0);
        // A set and a clear in the same cycle must leave the flag set.
        flag_op(4'h0, 4'h2, 4'h2, 1'b1);
        flag_op(4'h0, 4'h0, 4'h2, 1'b0);
        @(posedge clk);
        trig <= 4'h2;
        pulse(1, 3'h0, 2, seen);
        check("rise flag", {15'h0000, flag[1]}, 16'h0001);
    endtask : test_flags
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    initial begin
        {wr, rd, s_low, s_tick, rstn, addr, wdata, page} = '0;
        {trig, svc, fset, fclr, s_irq, s_pin} = '0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        test_regs();
        test_pins();
        test_filters();
        test_flags();
        complete_run();
    end
endmodule : eisfp_top_test
`default_nettype wire
